// *** core/dcs_pkg.sv ***
// Package for the drive command source and stop sequencer.
// Assumes a single 125 MHz controller clock; times are given in milliseconds.
package dcs_pkg;
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned TIME_UNIT_MS    = 1;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000 * TIME_UNIT_MS;
  // Reset values of the settings
  localparam logic [2:0]  FREQ_SRC_RST    = 3'h1;
  localparam logic [1:0]  RUN_SRC_RST     = 2'h1;
  localparam logic [1:0]  STOP_METH_RST   = 2'h0;
  localparam logic        REV_INH_RST     = 1'b0;
  localparam logic        SW_ACT_RST      = 1'b0;
  // Source codes
  localparam logic [2:0]  FSRC_KEYPAD     = 3'h0;
  localparam logic [2:0]  FSRC_ANALOG     = 3'h1;
  localparam logic [2:0]  FSRC_UPDOWN     = 3'h2;
  localparam logic [2:0]  FSRC_SERIAL     = 3'h3;
  localparam logic [2:0]  FSRC_PULSE      = 3'h4;
  localparam logic [1:0]  RSRC_KEYPAD     = 2'h0;
  localparam logic [1:0]  RSRC_TERM       = 2'h1;
  localparam logic [1:0]  RSRC_SERIAL     = 2'h2;
  // Stop methods
  localparam logic [1:0]  STOP_RAMP       = 2'h0;
  localparam logic [1:0]  STOP_COAST      = 2'h1;
  localparam logic [1:0]  STOP_INJECT     = 2'h2;
  localparam logic [1:0]  STOP_COAST_TMR  = 2'h3;
  // Function codes
  localparam logic [3:0]  AIN_FN_AUX      = 4'h3;
  localparam logic [3:0]  DIN_FN_FWD      = 4'h0;
  localparam logic [3:0]  DIN_FN_REV      = 4'h1;
  localparam logic [3:0]  DIN_FN_LOCREM   = 4'h3;
  localparam logic [3:0]  DIN_FN_SRC12    = 4'h4;
  localparam logic [3:0]  DIN_FN_3W_FWD   = 4'h5;
  localparam logic [3:0]  DIN_FN_3W_STOP  = 4'h6;
  localparam logic [3:0]  DIN_FN_3W_DIR   = 4'h7;
  localparam logic [3:0]  PULSE_FN_FREQ   = 4'h0;
  localparam logic [13:0] INIT_3WIRE      = 14'h0d02;  // 3330 decimal
  localparam int unsigned INJ_TIME_MULT   = 10;
  // Up/down step per input cycle, full scale of frequency words
  localparam logic [15:0] UPDN_STEP       = 16'h0001;
  localparam logic [15:0] FREQ_FULL       = 16'hffff;
  // Blink half period in ms
  localparam int unsigned BLINK_MS        = 250;
  localparam int unsigned BLINK_CYC       = BLINK_MS * CYC_PER_MS;
  typedef enum logic [2:0] {DCS_IDLE, DCS_RUN, DCS_RAMP, DCS_HOLD, DCS_OFFWAIT,
                            DCS_INJECT, DCS_LOCKOUT} dcs_state_t;
endpackage : dcs_pkg

// *** core/dcs_top.sv ***
// File holds the whole sequencer; assumes settings are held stable by the host
// controller, inputs are synchronous, and the ramp generator sits outside.
`timescale 1ns/1ns
module dcs_top #(
  parameter int unsigned FW       = 16,
  parameter int unsigned TMW      = 32,
  parameter int unsigned BLINK_CY = dcs_pkg::BLINK_CYC
) (
  input  wire logic          sys_clk,
  input  wire logic          sys_rst,
  input  wire logic [2:0]    freq_source_select_primary,
  input  wire logic [1:0]    run_source_select_primary,
  input  wire logic [1:0]    stop_method_select,
  input  wire logic          reverse_inhibit,
  input  wire logic          source_switch_run_action,
  input  wire logic [13:0]   initialisation_code,
  input  wire logic          init_write,
  input  wire logic [3:0]    control_method_select,
  input  wire logic [3:0]    analog_one_function,
  input  wire logic [3:0]    analog_two_function,
  input  wire logic [3:0]    pulse_input_function,
  input  wire logic [FW-1:0] pulse_input_scaling,
  input  wire logic [FW-1:0] hold_start_frequency,
  input  wire logic [FW-1:0] minimum_output_frequency,
  input  wire logic [FW-1:0] maximum_output_frequency,
  input  wire logic [FW-1:0] stop_braking_time,
  input  wire logic [FW-1:0] min_output_off_time,
  input  wire logic [FW-1:0] decel_time_one,
  input  wire logic [FW-1:0] keypad_freq,
  input  wire logic [FW-1:0] analog_input_one,
  input  wire logic [FW-1:0] analog_input_two,
  input  wire logic [FW-1:0] serial_freq,
  input  wire logic [FW-1:0] pulse_rate,
  input  wire logic [FW-1:0] multi_step_one,
  input  wire logic          multi_step_sel,
  input  wire logic          up_input,
  input  wire logic          down_input,
  input  wire logic          local_remote_key,
  input  wire logic          din_local_remote,
  input  wire logic          din_source_select,
  input  wire logic          keypad_run,
  input  wire logic          keypad_stop,
  input  wire logic          keypad_reverse,
  input  wire logic          digital_input_one,
  input  wire logic          digital_input_two,
  input  wire logic          digital_input_five,
  input  wire logic          serial_run,
  input  wire logic          serial_reverse,
  input  wire logic [FW-1:0] output_frequency,
  output logic [FW-1:0]      freq_command,
  output logic               run_enable,
  output logic               run_reverse,
  output logic               output_on,
  output logic               decel_active,
  output logic               brake_active,
  output logic               inject_enable,
  output logic               run_refused,
  output logic               run_led,
  output logic               local_mode,
  output logic [3:0]         input_one_function,
  output logic [3:0]         input_two_function,
  output logic [3:0]         input_five_function
);
  // Settings that the init code can reset, plus edge, accumulator, sequencer and blink state
  logic [2:0] fsrc_q;
  logic [1:0] rsrc_q, stop_q;
  logic       rev_q, swact_q;
  logic       local_q, key_q, din_lr_q, din_src_q;
  logic [FW-1:0] updn_q, freq_q;
  dcs_pkg::dcs_state_t state_q, state_d;
  logic [TMW-1:0] tmr_q, tmr_d, hold_q, hold_d;
  logic       need_release_q, blink_q;
  logic [31:0] blink_cnt_q;

  wire init_3w = init_write && (initialisation_code == dcs_pkg::INIT_3WIRE);

  // Latched settings; the three-wire init restores defaults and remaps inputs
  always_ff @(posedge sys_clk) begin
    if (sys_rst || init_3w) begin
      fsrc_q <= dcs_pkg::FREQ_SRC_RST;
      rsrc_q <= dcs_pkg::RUN_SRC_RST;
      stop_q <= dcs_pkg::STOP_METH_RST;
      rev_q  <= dcs_pkg::REV_INH_RST;
      swact_q <= dcs_pkg::SW_ACT_RST;
      input_one_function  <= init_3w ? dcs_pkg::DIN_FN_3W_FWD : dcs_pkg::DIN_FN_FWD;
      input_two_function  <= init_3w ? dcs_pkg::DIN_FN_3W_STOP : dcs_pkg::DIN_FN_REV;
      input_five_function <= init_3w ? dcs_pkg::DIN_FN_3W_DIR : dcs_pkg::DIN_FN_LOCREM;
    end else if (init_write) begin
      fsrc_q <= freq_source_select_primary;
      rsrc_q <= run_source_select_primary;
      stop_q <= stop_method_select;
      rev_q  <= reverse_inhibit;
      swact_q <= source_switch_run_action;
    end
  end

  // Edge detect of the source-switch triggers
  wire key_edge  = local_remote_key && !key_q;
  wire lr_edge   = din_local_remote != din_lr_q;
  wire src_edge  = din_source_select != din_src_q;
  wire switch_ev = key_edge || lr_edge || src_edge;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      key_q <= 1'b0;
      din_lr_q <= 1'b0;
      din_src_q <= 1'b0;
      local_q <= 1'b0;
    end else begin
      key_q <= local_remote_key;
      din_lr_q <= din_local_remote;
      din_src_q <= din_source_select;
      if (key_edge || lr_edge)
        local_q <= !local_q;
    end
  end
  assign local_mode = local_q;

  // Step one of multi-step follows an auxiliary analog input
  wire aux_one = analog_one_function == dcs_pkg::AIN_FN_AUX;
  wire aux_two = analog_two_function == dcs_pkg::AIN_FN_AUX;
  wire [FW-1:0] step_one = aux_one ? analog_input_one :
                           aux_two ? analog_input_two : multi_step_one;
  wire [FW-1:0] keypad_val = multi_step_sel ? step_one : keypad_freq;
  // Pulse rate scaled so that rate equal to the scaling gives full command
  wire [2*FW-1:0] pulse_prod = pulse_rate * dcs_pkg::FREQ_FULL;
  wire [2*FW-1:0] pulse_quot = (pulse_input_scaling == '0) ? '0 :
                               pulse_prod / pulse_input_scaling;
  wire [FW-1:0] pulse_val = (pulse_input_function != dcs_pkg::PULSE_FN_FREQ) ? '0 :
                            (pulse_quot > dcs_pkg::FREQ_FULL) ? dcs_pkg::FREQ_FULL :
                            pulse_quot[FW-1:0];
  wire [2:0] fsel = local_q ? dcs_pkg::FSRC_KEYPAD : fsrc_q;
  logic [FW-1:0] freq_sel;
  always_comb begin
    case (fsel)
      dcs_pkg::FSRC_KEYPAD: freq_sel = keypad_val;
      dcs_pkg::FSRC_ANALOG: freq_sel = aux_one ? analog_input_two : analog_input_one;
      dcs_pkg::FSRC_UPDOWN: freq_sel = updn_q;
      dcs_pkg::FSRC_SERIAL: freq_sel = serial_freq;
      dcs_pkg::FSRC_PULSE:  freq_sel = pulse_val;
      default:              freq_sel = '0;
    endcase
  end

  // Up/down accumulator, saturating at both ends
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      updn_q <= '0;
    else if (fsel == dcs_pkg::FSRC_UPDOWN && up_input && !down_input && updn_q != '1)
      updn_q <= updn_q + dcs_pkg::UPDN_STEP;
    else if (fsel == dcs_pkg::FSRC_UPDOWN && down_input && !up_input && updn_q != '0)
      updn_q <= updn_q - dcs_pkg::UPDN_STEP;
  end

  // Run source selection; local mode always runs from the keypad
  wire [1:0] rsel = local_q ? dcs_pkg::RSRC_KEYPAD : rsrc_q;
  wire three_w = input_one_function == dcs_pkg::DIN_FN_3W_FWD;
  logic run_req, rev_req;
  always_comb begin
    case (rsel)
      dcs_pkg::RSRC_KEYPAD: begin
        run_req = keypad_run && !keypad_stop;
        rev_req = keypad_reverse;
      end
      dcs_pkg::RSRC_TERM: begin
        // Two-wire relies on the operator mapping inputs one and two
        run_req = three_w ? (digital_input_one && digital_input_two)
                          : (digital_input_one ^ digital_input_two);
        rev_req = three_w ? digital_input_five : digital_input_two;
      end
      dcs_pkg::RSRC_SERIAL: begin
        run_req = serial_run;
        rev_req = serial_reverse;
      end
      default: begin
        run_req = 1'b0;
        rev_req = 1'b0;
      end
    endcase
  end
  wire run_ok = run_req && !(rev_q && rev_req);

  // After a source switch with action 0 the run must drop before it counts
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      need_release_q <= 1'b0;
    else if (switch_ev && !swact_q)
      need_release_q <= 1'b1;
    else if (!run_req)
      need_release_q <= 1'b0;
  end
  wire run_valid = run_ok && !need_release_q;

  // Stop thresholds and timed durations
  wire [FW-1:0] brake_thr = (hold_start_frequency < minimum_output_frequency) ?
                            minimum_output_frequency : hold_start_frequency;
  wire pm_method = control_method_select == 4'h4 || control_method_select == 4'h5 ||
                   control_method_select == 4'h6 || control_method_select == 4'h8;
  wire [1:0] meth_eff = (stop_q == dcs_pkg::STOP_INJECT && pm_method) ?
                        dcs_pkg::STOP_COAST : stop_q;
  wire [FW-1:0] maxf = (maximum_output_frequency == '0) ? 16'h0001 : maximum_output_frequency;
  // Products formed at 64 bits so large settings cannot wrap before the divide
  wire [TMW-1:0] inj_ms = TMW'(64'(stop_braking_time) * dcs_pkg::INJ_TIME_MULT
                          * output_frequency / maxf);
  wire [TMW-1:0] tmr_ms = TMW'(64'(output_frequency) * decel_time_one / maxf);
  wire [TMW-1:0] off_cyc = TMW'(min_output_off_time * dcs_pkg::CYC_PER_MS);
  wire [TMW-1:0] brk_cyc = TMW'(stop_braking_time * dcs_pkg::CYC_PER_MS);
  wire stop_ev = !run_valid;

  // Stop sequencer
  always_comb begin
    state_d = state_q;
    tmr_d = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
    hold_d = hold_q;
    case (state_q)
      dcs_pkg::DCS_IDLE:
        if (run_valid)
          state_d = dcs_pkg::DCS_RUN;
      dcs_pkg::DCS_RUN:
        if (stop_ev) begin
          case (meth_eff)
            dcs_pkg::STOP_RAMP: state_d = dcs_pkg::DCS_RAMP;
            dcs_pkg::STOP_COAST: begin
              state_d = dcs_pkg::DCS_LOCKOUT;
              tmr_d = off_cyc;
            end
            dcs_pkg::STOP_INJECT: begin
              state_d = dcs_pkg::DCS_OFFWAIT;
              tmr_d = off_cyc;
              hold_d = TMW'(inj_ms * dcs_pkg::CYC_PER_MS);
            end
            default: begin
              state_d = dcs_pkg::DCS_LOCKOUT;
              tmr_d = TMW'(tmr_ms * dcs_pkg::CYC_PER_MS);
            end
          endcase
        end
      dcs_pkg::DCS_RAMP:
        if (output_frequency < brake_thr) begin
          state_d = dcs_pkg::DCS_HOLD;
          tmr_d = brk_cyc;
        end
      dcs_pkg::DCS_OFFWAIT:
        if (tmr_q == '0) begin
          state_d = dcs_pkg::DCS_INJECT;
          tmr_d = hold_q;
        end
      dcs_pkg::DCS_HOLD, dcs_pkg::DCS_INJECT, dcs_pkg::DCS_LOCKOUT:
        if (tmr_q == '0)
          state_d = dcs_pkg::DCS_IDLE;
      default: state_d = dcs_pkg::DCS_IDLE;
    endcase
  end

  // Sequencer registers; the stop state and its timer carry the method chosen at the stop
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= dcs_pkg::DCS_IDLE;
      tmr_q <= '0;
      hold_q <= '0;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      hold_q <= hold_d;
    end
  end

  // Run indicator blinks while run is asked with too low a command
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
    end else if (blink_cnt_q >= BLINK_CY - 1) begin
      blink_cnt_q <= '0;
      blink_q <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h1;
    end
  end
  wire low_cmd = freq_sel == '0 || freq_sel < minimum_output_frequency;

  // Registered outputs, then status outputs decoded from state_q and run_req
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      freq_command <= '0;
      run_reverse <= 1'b0;
      run_led <= 1'b0;
    end else begin
      freq_command <= freq_sel;
      if (state_q == dcs_pkg::DCS_IDLE)
        run_reverse <= rev_req && !rev_q;
      run_led <= (state_q == dcs_pkg::DCS_RUN) ? (low_cmd ? blink_q : 1'b1) : 1'b0;
    end
  end
  assign run_enable    = state_q == dcs_pkg::DCS_RUN;
  assign output_on     = state_q == dcs_pkg::DCS_RUN || state_q == dcs_pkg::DCS_RAMP ||
                         state_q == dcs_pkg::DCS_HOLD || state_q == dcs_pkg::DCS_INJECT;
  assign decel_active  = state_q == dcs_pkg::DCS_RAMP;
  assign brake_active  = state_q == dcs_pkg::DCS_HOLD;
  assign inject_enable = state_q == dcs_pkg::DCS_INJECT;
  assign run_refused   = state_q == dcs_pkg::DCS_LOCKOUT && run_req;
endmodule : dcs_top

// *** sim/dcs_panel.sv ***
// Model of the keypad, input terminals and serial master feeding the sequencer.
// Assumes bench requests are levels; every line changes just after a rising edge.
`timescale 1ns/1ns
module dcs_panel (
  input  wire logic sys_clk,
  input  wire logic fwd_req,
  input  wire logic rev_req,
  output wire logic digital_input_one,
  output wire logic digital_input_two,
  output wire logic digital_input_five,
  output wire logic keypad_run,
  output wire logic keypad_stop,
  output wire logic keypad_reverse,
  output wire logic serial_run,
  output wire logic serial_reverse
);
  logic fwd_q = 1'b0;
  logic rev_q = 1'b0;
  // Retimed so the sequencer never samples a request mid-change
  always @(posedge sys_clk) begin
    fwd_q <= fwd_req;
    rev_q <= rev_req;
  end
  // Two-wire wiring: forward/stop on input one, reverse/stop on input two
  assign digital_input_one  = fwd_q;
  assign digital_input_two  = rev_q;
  assign digital_input_five = rev_q;
  assign keypad_run         = fwd_q | rev_q;
  assign keypad_stop        = 1'b0;
  assign keypad_reverse     = rev_q;
  assign serial_run         = fwd_q | rev_q;
  assign serial_reverse     = rev_q;
endmodule : dcs_panel

// *** sim/dcs_top_assertions.sv ***
// Port-level assertions for the command source and stop sequencer.
// Bound into dcs_top below; one clock domain, synchronous active-high reset.
`timescale 1ns/1ns
module dcs_top_assertions #(
  parameter int unsigned FW       = 16,
  parameter int unsigned BLINK_CY = dcs_pkg::BLINK_CYC
) (
  input wire logic          sys_clk,
  input wire logic          sys_rst,
  input wire logic [1:0]    stop_method_select,
  input wire logic          reverse_inhibit,
  input wire logic [13:0]   initialisation_code,
  input wire logic          init_write,
  input wire logic          local_remote_key,
  input wire logic [FW-1:0] keypad_freq,
  input wire logic [FW-1:0] hold_start_frequency,
  input wire logic [FW-1:0] minimum_output_frequency,
  input wire logic [FW-1:0] output_frequency,
  input wire logic [FW-1:0] freq_command,
  input wire logic          run_enable,
  input wire logic          run_reverse,
  input wire logic          output_on,
  input wire logic          decel_active,
  input wire logic          run_led,
  input wire logic          local_mode,
  input wire logic [3:0]    input_one_function,
  input wire logic [3:0]    input_two_function,
  input wire logic [3:0]    input_five_function
);
  logic [1:0]    sm_q;
  logic          ri_q;
  wire  [FW-1:0] thr_w = (hold_start_frequency < minimum_output_frequency) ?
                         minimum_output_frequency : hold_start_frequency;
  // Shadow of the latched settings, since the design hides its copy
  always_ff @(posedge sys_clk) begin
    if (sys_rst || (init_write && initialisation_code == dcs_pkg::INIT_3WIRE)) begin
      sm_q <= dcs_pkg::STOP_METH_RST;
      ri_q <= dcs_pkg::REV_INH_RST;
    end else if (init_write) begin
      sm_q <= stop_method_select;
      ri_q <= reverse_inhibit;
    end
  end
  // Cycles the indicator has held one level while running on a low command
  logic [31:0] still_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !(run_enable && freq_command < minimum_output_frequency) ||
        !$stable(run_led))
      still_q <= '0;
    else
      still_q <= still_q + 32'h1;
  end
  default clocking dcs_cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Stop steps: ramp crossing the braking threshold, and a coasting cut
  sequence s_ramp_low;
    decel_active && output_frequency < thr_w;
  endsequence
  sequence s_coast_stop;
    $fell(run_enable) && sm_q[0];
  endsequence
  chk_reset_clears_all:
    assert property ($fell(sys_rst) |-> !run_enable && !output_on && freq_command == '0 &&
      {input_one_function, input_two_function, input_five_function} == 12'h013)
      else $error("state after reset is wrong");
  chk_three_wire_map:
    assert property (init_write && initialisation_code == dcs_pkg::INIT_3WIRE |=>
      {input_one_function, input_two_function, input_five_function} == 12'h567)
      else $error("three-wire map missing");
  chk_local_keypad_freq:
    assert property ((local_mode && $stable(keypad_freq))[*3] |-> freq_command == keypad_freq)
      else $error("local mode not on keypad frequency");
  chk_key_goes_local:
    assert property ($rose(local_remote_key) && !local_mode |-> ##[1:2] local_mode)
      else $error("key press did not select local");
  chk_reverse_blocked:
    assert property (ri_q |-> !(run_enable && run_reverse))
      else $error("reverse run while inhibited");
  chk_coast_cuts_out:
    assert property (s_coast_stop |-> !output_on && !decel_active)
      else $error("coast stop left output on");
  chk_ramp_ends_low:
    assert property (s_ramp_low |=> !decel_active)
      else $error("ramp went on below threshold");
  chk_led_blinks:
    assert property (still_q <= BLINK_CY + 4)
      else $error("run indicator not blinking");
endmodule : dcs_top_assertions

bind dcs_top dcs_top_assertions #(.FW(FW), .BLINK_CY(BLINK_CY)) dcs_top_assertions_i (.*);

// *** sim/dcs_top_bench.sv ***
// Self-checking bench: drives the sequencer through its panel model, checks results.
// Assumes package, design, checker and panel model are compiled before it.
`timescale 1ns/1ns
module dcs_top_bench;
  logic        sys_clk = 1'b1, sys_rst = 1'b1, init_write = 1'b0, reverse_inhibit = 1'b0;
  logic        source_switch_run_action = 1'b0, multi_step_sel = 1'b0, up_input = 1'b0;
  logic        down_input = 1'b0, local_remote_key = 1'b0, din_local_remote = 1'b0;
  logic        din_source_select = 1'b0, fwd_req = 1'b0, rev_req = 1'b0;
  logic [2:0]  freq_source_select_primary = 3'h1;
  logic [1:0]  run_source_select_primary = 2'h1, stop_method_select = 2'h0;
  logic [13:0] initialisation_code = 14'h0000;
  logic [3:0]  control_method_select = 4'h0, analog_one_function = 4'h0;
  logic [3:0]  analog_two_function = 4'h0, pulse_input_function = 4'h0;
  logic [15:0] pulse_input_scaling = 16'h0800, hold_start_frequency = 16'h0010;
  logic [15:0] minimum_output_frequency = 16'h0020, maximum_output_frequency = 16'hc000;
  logic [15:0] stop_braking_time = 16'h0000, min_output_off_time = 16'h0000;
  logic [15:0] decel_time_one = 16'h0000, keypad_freq = 16'h0100, analog_input_one = 16'h1234;
  logic [15:0] analog_input_two = 16'h2345, serial_freq = 16'h0abc, pulse_rate = 16'h0800;
  logic [15:0] multi_step_one = 16'h0300, output_frequency = 16'h0000, snap, cnt;
  wire  logic  digital_input_one, digital_input_two, digital_input_five, keypad_run;
  wire  logic  keypad_stop, keypad_reverse, serial_run, serial_reverse, run_enable;
  wire  logic  run_reverse, output_on, decel_active, brake_active, inject_enable;
  wire  logic  run_refused, run_led, local_mode;
  wire  logic [15:0] freq_command;
  wire  logic [3:0]  input_one_function, input_two_function, input_five_function;
  int          bad_count = 0, check_count = 0, cycles = 0;
  int          inj_seen = 0, brk_seen = 0, ref_seen = 0;
  logic [2:0]  fs_tab [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
  logic [15:0] fx_tab [4] = '{16'h0100, 16'h1234, 16'h0abc, dcs_pkg::FREQ_FULL};

  dcs_top #(.BLINK_CY(4)) dcs_top_i (.*);
  dcs_panel dcs_panel_i (.*);

  // Free-running 125 MHz clock
  initial forever #4 sys_clk = ~sys_clk;
  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // One-cycle stop states tallied at falling edges, where they have settled
  always @(negedge sys_clk) begin
    inj_seen += int'(inject_enable === 1'b1);
    brk_seen += int'(brake_active === 1'b1);
    ref_seen += int'(run_refused === 1'b1);
  end
  // Stimulus moves on falling edges so the rising edge sees settled inputs
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Settings only land with a one-cycle init_write pulse
  task automatic set_cfg(input logic [2:0] fs, input logic [1:0] rs, input logic [1:0] sm,
                         input logic ri, input logic sa);
    freq_source_select_primary = fs;
    run_source_select_primary = rs;
    stop_method_select = sm;
    reverse_inhibit = ri;
    source_switch_run_action = sa;
    init_write = 1'b1;
    tick(1);
    init_write = 1'b0;
    tick(1);
  endtask : set_cfg
  // Run requests wait on run_enable with a bound; halt waits for a quiet output
  task automatic go(input logic rev);
    fwd_req = !rev;
    rev_req = rev;
    for (int i = 0; i < 20 && run_enable !== 1'b1; i++) tick(1);
  endtask : go
  task automatic halt();
    fwd_req = 1'b0;
    rev_req = 1'b0;
    for (int i = 0; i < 40 && {run_enable, output_on, decel_active} !== 3'h0; i++) tick(1);
    tick(4);
  endtask : halt
  task automatic press();
    local_remote_key = 1'b1;
    tick(1);
    local_remote_key = 1'b0;
    tick(3);
  endtask : press
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    tick(16);
    sys_rst = 1'b0;
    tick(3);
    check("map", 16'h0013, 16'({input_one_function, input_two_function, input_five_function}));
    check("default source", analog_input_one, freq_command);
    set_cfg(3'h2, 2'h1, 2'h0, 1'b0, 1'b0);
    snap = freq_command;
    up_input = 1'b1;
    tick(5);
    up_input = 1'b0;
    tick(2);
    check("up", 16'h0001, 16'(freq_command > snap));
    snap = freq_command;
    down_input = 1'b1;
    tick(3);
    down_input = 1'b0;
    tick(2);
    check("down", 16'h0001, 16'(freq_command < snap));
    foreach (fs_tab[k]) begin
      set_cfg(fs_tab[k], 2'h1, 2'h0, 1'b0, 1'b0);
      tick(2);
      check("source", fx_tab[k], freq_command);
    end
    press();
    check("local", 16'h0001, 16'({local_mode, freq_command == keypad_freq} == 2'h3));
    press();
    check("remote", dcs_pkg::FREQ_FULL, freq_command);
    analog_one_function = dcs_pkg::AIN_FN_AUX;
    multi_step_sel = 1'b1;
    set_cfg(3'h0, 2'h1, 2'h0, 1'b0, 1'b0);
    check("aux step", analog_input_one, freq_command);
    set_cfg(3'h1, 2'h1, 2'h0, 1'b0, 1'b0);
    check("aux main", analog_input_two, freq_command);
    analog_one_function = 4'h0;
    multi_step_sel = 1'b0;
    $display("test sources done");
    for (int r = 0; r < 3; r++) begin
      set_cfg(3'h1, 2'(r), 2'h0, 1'b0, 1'b0);
      go(1'b0);
      check("run", 16'h0002, 16'({run_enable, run_reverse}));
      halt();
    end
    set_cfg(3'h1, 2'h1, 2'h0, 1'b0, 1'b0);
    go(1'b1);
    check("reverse", 16'h0003, 16'({run_enable, run_reverse}));
    halt();
    set_cfg(3'h1, 2'h1, 2'h0, 1'b1, 1'b0);
    go(1'b1);
    check("reverse blocked", 16'h0000, 16'(run_enable));
    halt();
    $display("test run sources done");
    set_cfg(3'h1, 2'h1, 2'h0, 1'b0, 1'b0);
    output_frequency = 16'h4000;
    go(1'b0);
    fwd_req = 1'b0;
    tick(3);
    check("ramp", 16'h0003, 16'({decel_active, output_on}));
    snap = 16'(brk_seen);
    output_frequency = 16'h0018;
    tick(3);
    check("ramp end", 16'h0000, 16'(decel_active));
    check("brake", 16'h0001, 16'(brk_seen) - snap);
    halt();
    for (int m = 1; m < 4; m++) begin
      control_method_select = (m == 2) ? 4'h4 : 4'h0;
      set_cfg(3'h1, 2'h1, 2'(m), 1'b0, 1'b0);
      output_frequency = 16'h4000;
      go(1'b0);
      fwd_req = 1'b0;
      tick(3);
      check("cut", 16'h0000, 16'({run_enable, decel_active, output_on}));
      output_frequency = 16'h0000;
      halt();
    end
    set_cfg(3'h1, 2'h1, 2'h2, 1'b0, 1'b0);
    snap = 16'(inj_seen);
    go(1'b0);
    halt();
    check("inject", 16'h0001, 16'(inj_seen) - snap);
    $display("test stops done");
    analog_input_one = 16'h0000;
    set_cfg(3'h1, 2'h1, 2'h1, 1'b0, 1'b0);
    go(1'b0);
    cnt = 16'h0000;
    repeat (12) begin
      tick(1);
      cnt = cnt + 16'(run_led);
    end
    check("blink", 16'h0001, 16'(cnt > 16'h0000 && cnt < 16'h000c));
    analog_input_one = 16'h1234;
    snap = 16'(ref_seen);
    din_source_select = 1'b1;
    tick(6);
    check("switch stops", 16'h0000, 16'(run_enable));
    check("refused", 16'h0001, 16'(ref_seen) - snap);
    halt();
    go(1'b0);
    check("reapplied", 16'h0001, 16'(run_enable));
    halt();
    set_cfg(3'h1, 2'h1, 2'h1, 1'b0, 1'b1);
    go(1'b0);
    din_source_select = 1'b0;
    tick(6);
    check("switch keeps", 16'h0001, 16'(run_enable));
    halt();
    $display("test switch done");
    set_cfg(3'h3, 2'h1, 2'h0, 1'b0, 1'b0);
    initialisation_code = dcs_pkg::INIT_3WIRE;
    init_write = 1'b1;
    tick(1);
    init_write = 1'b0;
    tick(3);
    check("3wire", 16'h0567, 16'({input_one_function, input_two_function, input_five_function}));
    check("defaults", analog_input_one, freq_command);
    $display("test init done");
    report_and_stop();
  end
endmodule : dcs_top_bench
